// ==== hdl/blg_pkg.sv ====
// What this block does
// - and gate output high only when every considered input is high
// - and gate treats an unconnected input as high
// - and gate with no input connected drives low
// - or gate output high when any input is high
// - or gate treats an unconnected input as low
// - inverter output is the inverse of its input
// - inverter with unconnected input drives low
// - xor gate high when its two inputs differ, low when equal
// - nand gate low only when all considered inputs are high
// - nor gate high only when all considered inputs are low
// - gate inputs are single bits only
// - gates carry no adjustable settings; type and wiring fix behaviour
// - key input asserted exactly while the key is held
// - monitor value overrides are volatile, dropped on leaving monitor
// - set-point changes in monitor are kept after leaving monitor; only reset clears them
// - forced output only applies where the program does not drive it
// - forcing a physical input never changes its hardware-driven state
// - block create or remove is refused in monitor mode
// - eight keys and twenty-four memory bits always present
package blg_pkg;
   // ----------------------------------------
   // sizes and timing
   // ----------------------------------------
   localparam int NUM_KEYS = 8;
   localparam int NUM_MBITS = 24;
   localparam int GATE_PINS = 4;
   localparam int XOR_PINS = 2;
   localparam int SETPT_W = 16;
   localparam int SCAN_US = 10;
   localparam int CLK_MHZ = 200;
   localparam int SCAN_CYC = SCAN_US * CLK_MHZ;
   localparam logic [3:0] AND_RST = 4'h0;
   // ----------------------------------------
   // gate result indices
   // ----------------------------------------
   localparam int G_AND = 0;
   localparam int G_OR = 1;
   localparam int G_NOT = 2;
   localparam int G_XOR = 3;
   localparam int G_NAND = 4;
   localparam int G_NOR = 5;
   localparam int NUM_GATES = 6;
endpackage : blg_pkg

// ==== hdl/blg_gate_eval.sv ====
`timescale 1ns/10ps
module blg_gate_eval
   import blg_pkg::*;
(
   // pin values and connection masks
   input wire logic [GATE_PINS-1:0] and_val_in,
   input wire logic [GATE_PINS-1:0] and_con_in,
   input wire logic [GATE_PINS-1:0] or_val_in,
   input wire logic [GATE_PINS-1:0] or_con_in,
   input wire logic not_val_in,
   input wire logic not_con_in,
   input wire logic [XOR_PINS-1:0] xor_val_in,
   input wire logic [XOR_PINS-1:0] xor_con_in,
   input wire logic [GATE_PINS-1:0] nand_val_in,
   input wire logic [GATE_PINS-1:0] nand_con_in,
   input wire logic [GATE_PINS-1:0] nor_val_in,
   input wire logic [GATE_PINS-1:0] nor_con_in,
   // results
   output logic [NUM_GATES-1:0] gate_out
);
   // ----------------------------------------
   // pure combinational evaluation
   // ----------------------------------------
   function automatic logic and_fn(input logic [GATE_PINS-1:0] v,
                                   input logic [GATE_PINS-1:0] c);
      and_fn = (|c) & (&(v | ~c));
   endfunction : and_fn

   function automatic logic or_fn(input logic [GATE_PINS-1:0] v,
                                  input logic [GATE_PINS-1:0] c);
      or_fn = |(v & c);
   endfunction : or_fn

   always_comb begin
      gate_out[G_AND] = and_fn(and_val_in, and_con_in);
      gate_out[G_OR] = or_fn(or_val_in, or_con_in);
      gate_out[G_NOT] = not_con_in & ~not_val_in;
      gate_out[G_XOR] = ^(xor_val_in & xor_con_in);
      // no input wired gives low, as for and
      gate_out[G_NAND] = (|nand_con_in) &
         ~(&(nand_val_in | ~nand_con_in));
      gate_out[G_NOR] = (|nor_con_in) & ~or_fn(nor_val_in, nor_con_in);
   end
endmodule : blg_gate_eval

// ==== hdl/blg_logic_top.sv ====
`timescale 1ns/10ps
module blg_logic_top
   import blg_pkg::*;
#(
   parameter int SCAN_CYCLES = SCAN_CYC
)(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // front panel keys and hardware inputs, asynchronous
   input wire logic [NUM_KEYS-1:0] key_pin_in,
   input wire logic [GATE_PINS-1:0] hw_input_pin_in,
   // gate wiring: one bit per pin, single-bit values only
   input wire logic [GATE_PINS-1:0] and_val_in,
   input wire logic [GATE_PINS-1:0] and_con_in,
   input wire logic [GATE_PINS-1:0] or_val_in,
   input wire logic [GATE_PINS-1:0] or_con_in,
   input wire logic not_val_in,
   input wire logic not_con_in,
   input wire logic [XOR_PINS-1:0] xor_val_in,
   input wire logic [XOR_PINS-1:0] xor_con_in,
   input wire logic [GATE_PINS-1:0] nand_val_in,
   input wire logic [GATE_PINS-1:0] nand_con_in,
   input wire logic [GATE_PINS-1:0] nor_val_in,
   input wire logic [GATE_PINS-1:0] nor_con_in,
   // monitor mode and memory bits
   input wire logic monitor_mode_in,
   input wire logic [NUM_MBITS-1:0] mbit_set_in,
   input wire logic [NUM_MBITS-1:0] mbit_val_in,
   // forcing of outputs and physical inputs
   input wire logic [NUM_GATES-1:0] out_prog_drv_in,
   input wire logic [NUM_GATES-1:0] force_req_in,
   input wire logic [NUM_GATES-1:0] force_val_in,
   input wire logic [GATE_PINS-1:0] input_force_req_in,
   // current value override and set point
   input wire logic cur_wr_in,
   input wire logic [SETPT_W-1:0] cur_data_in,
   input wire logic setpt_wr_in,
   input wire logic [SETPT_W-1:0] setpt_data_in,
   // block structure edits
   input wire logic blk_add_in,
   input wire logic blk_del_in,
   // results
   output logic [NUM_GATES-1:0] gate_out,
   output logic [NUM_GATES-1:0] sys_output_out,
   output logic [NUM_KEYS-1:0] key_out,
   output logic [GATE_PINS-1:0] hw_input_out,
   output logic [NUM_MBITS-1:0] mbit_out,
   output logic scan_done_out,
   output logic [SETPT_W-1:0] cur_value_out,
   output logic [SETPT_W-1:0] setpt_out,
   output logic edit_ok_out,
   output logic edit_reject_out
);
   // ----------------------------------------
   // scan divider
   // ----------------------------------------
   logic [15:0] scan_cnt_reg;
   logic scan_tick;
   assign scan_tick = (scan_cnt_reg == 16'(SCAN_CYCLES - 1));

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || scan_tick) begin
         scan_cnt_reg <= 16'h0000;
      end else begin
         scan_cnt_reg <= scan_cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         scan_done_out <= 1'b0;
      end else begin
         scan_done_out <= scan_tick;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [NUM_KEYS-1:0] key_meta_reg;
   logic [NUM_KEYS-1:0] key_sync_reg;
   logic [GATE_PINS-1:0] hw_meta_reg;
   logic [GATE_PINS-1:0] hw_sync_reg;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         key_meta_reg <= 8'h00;
         key_sync_reg <= 8'h00;
         hw_meta_reg <= 4'h0;
         hw_sync_reg <= 4'h0;
      end else begin
         key_meta_reg <= key_pin_in;
         key_sync_reg <= key_meta_reg;
         hw_meta_reg <= hw_input_pin_in;
         hw_sync_reg <= hw_meta_reg;
      end
   end

   // keys follow the held level, no latching or debounce
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         key_out <= 8'h00;
      end else begin
         key_out <= key_sync_reg;
      end
   end

   // force requests on physical inputs are ignored on purpose
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         hw_input_out <= 4'h0;
      end else begin
         hw_input_out <= hw_sync_reg;
      end
   end

   // ----------------------------------------
   // memory bits
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MBITS; gi++) begin : g_mbit
         always_ff @(posedge clk_sys_in) begin
            if (sys_rst_in) begin
               mbit_out[gi] <= 1'b0;
            end else if (mbit_set_in[gi]) begin
               mbit_out[gi] <= mbit_val_in[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // input latch and gate evaluation
   // ----------------------------------------
   // latching once per scan keeps all gates on one consistent snapshot
   logic [GATE_PINS-1:0] and_v_reg, and_c_reg, or_v_reg, or_c_reg;
   logic [GATE_PINS-1:0] nand_v_reg, nand_c_reg, nor_v_reg, nor_c_reg;
   logic [XOR_PINS-1:0] xor_v_reg, xor_c_reg;
   logic not_v_reg, not_c_reg;
   logic [NUM_GATES-1:0] gate_next;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         and_v_reg <= AND_RST;
         and_c_reg <= AND_RST;
         or_v_reg <= 4'h0;
         or_c_reg <= 4'h0;
         nand_v_reg <= 4'h0;
         nand_c_reg <= 4'h0;
         nor_v_reg <= 4'h0;
         nor_c_reg <= 4'h0;
         xor_v_reg <= 2'h0;
         xor_c_reg <= 2'h0;
         not_v_reg <= 1'b0;
         not_c_reg <= 1'b0;
      end else if (scan_tick) begin
         and_v_reg <= and_val_in;
         and_c_reg <= and_con_in;
         or_v_reg <= or_val_in;
         or_c_reg <= or_con_in;
         nand_v_reg <= nand_val_in;
         nand_c_reg <= nand_con_in;
         nor_v_reg <= nor_val_in;
         nor_c_reg <= nor_con_in;
         xor_v_reg <= xor_val_in;
         xor_c_reg <= xor_con_in;
         not_v_reg <= not_val_in;
         not_c_reg <= not_con_in;
      end
   end

   // fixed gate set, no settings port exists at all
   blg_gate_eval u_eval (
      .and_val_in(and_v_reg),
      .and_con_in(and_c_reg),
      .or_val_in(or_v_reg),
      .or_con_in(or_c_reg),
      .not_val_in(not_v_reg),
      .not_con_in(not_c_reg),
      .xor_val_in(xor_v_reg),
      .xor_con_in(xor_c_reg),
      .nand_val_in(nand_v_reg),
      .nand_con_in(nand_c_reg),
      .nor_val_in(nor_v_reg),
      .nor_con_in(nor_c_reg),
      .gate_out(gate_next)
   );

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         gate_out <= 6'h00;
      end else if (scan_tick) begin
         gate_out <= gate_next;
      end
   end

   // ----------------------------------------
   // output forcing
   // ----------------------------------------
   logic [NUM_GATES-1:0] force_hold_reg;
   logic [NUM_GATES-1:0] force_lvl_reg;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !monitor_mode_in) begin
         force_hold_reg <= 6'h00;
         force_lvl_reg <= 6'h00;
      end else begin
         force_hold_reg <= force_hold_reg | force_req_in;
         force_lvl_reg <= (force_lvl_reg & ~force_req_in) |
            (force_val_in & force_req_in);
      end
   end

   // program-driven outputs ignore any force
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         sys_output_out <= 6'h00;
      end else begin
         sys_output_out <= (gate_out & (out_prog_drv_in | ~force_hold_reg))
            | (force_lvl_reg & force_hold_reg & ~out_prog_drv_in);
      end
   end

   // ----------------------------------------
   // current value and set point
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !monitor_mode_in) begin
         cur_value_out <= 16'h0000;
      end else if (cur_wr_in) begin
         cur_value_out <= cur_data_in;
      end
   end

   // survives leaving monitor; only reset clears it
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         setpt_out <= 16'h0000;
      end else if (setpt_wr_in) begin
         setpt_out <= setpt_data_in;
      end
   end

   // ----------------------------------------
   // structure edit gate
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         edit_ok_out <= 1'b0;
         edit_reject_out <= 1'b0;
      end else begin
         edit_ok_out <= (blk_add_in | blk_del_in) & ~monitor_mode_in;
         edit_reject_out <= (blk_add_in | blk_del_in) & monitor_mode_in;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // gate results land one scan after the snapshot, so check the snapshot
   and_empty_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && and_c_reg == 4'h0 |=> !gate_out[G_AND])
      else $error("and output high with no input");
   and_full_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && and_c_reg != 4'h0 && (and_v_reg | ~and_c_reg) == 4'hF
      |-> ##1 gate_out[G_AND])
      else $error("and output low with all inputs high");
   and_low_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && (and_v_reg & and_c_reg) != and_c_reg |=> !gate_out[G_AND])
      else $error("and output high with a low input");
   or_any_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick |=> gate_out[G_OR] == |($past(or_v_reg) & $past(or_c_reg)))
      else $error("or output wrong");
   not_inv_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && not_c_reg |=> gate_out[G_NOT] == !$past(not_v_reg))
      else $error("not output wrong");
   not_open_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && !not_c_reg |=> !gate_out[G_NOT])
      else $error("not output high with no input");
   xor_diff_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && xor_c_reg == 2'h3 |=> gate_out[G_XOR] ==
         ($past(xor_v_reg) == 2'h1 || $past(xor_v_reg) == 2'h2))
      else $error("xor output wrong");
   xor_open_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && xor_c_reg == 2'h0 |=> !gate_out[G_XOR])
      else $error("xor output high with no input");
   nand_low_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && (nand_v_reg | ~nand_c_reg) == 4'hF |=> !gate_out[G_NAND])
      else $error("nand output high with all inputs high");
   nand_high_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && (nand_v_reg & nand_c_reg) != nand_c_reg |=> gate_out[G_NAND])
      else $error("nand output low with a low input");
   nor_high_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && nor_c_reg != 4'h0 && (nor_v_reg & nor_c_reg) == 4'h0
      |=> gate_out[G_NOR])
      else $error("nor output low with all inputs low");
   nor_low_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_tick && (nor_v_reg & nor_c_reg) != 4'h0 |=> !gate_out[G_NOR])
      else $error("nor output high with a high input");
   gate_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !scan_tick |=> $stable(gate_out))
      else $error("gate output moved between scans");
   scan_pulse_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      scan_done_out |=> !scan_done_out)
      else $error("scan done longer than one cycle");
   key_follow_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      ##3 key_out == $past(key_pin_in, 3))
      else $error("key output not following key");
   hw_input_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      ##3 hw_input_out == $past(hw_input_pin_in, 3))
      else $error("physical input state changed by force");
   hw_force_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      input_force_req_in != 4'h0
      |-> ##3 hw_input_out == $past(hw_input_pin_in, 3))
      else $error("forced physical input left its pin");
   mbit_hold_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      mbit_set_in == 24'h000000 |=> $stable(mbit_out))
      else $error("memory bit moved without a write");
   edit_lock_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      monitor_mode_in && (blk_add_in || blk_del_in)
      |=> edit_reject_out && !edit_ok_out)
      else $error("edit accepted in monitor mode");
   edit_idle_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !blk_add_in && !blk_del_in |=> !edit_ok_out && !edit_reject_out)
      else $error("edit answer without a request");
   cur_drop_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !monitor_mode_in |=> cur_value_out == 16'h0000)
      else $error("override kept outside monitor");
   cur_write_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      monitor_mode_in && cur_wr_in |=> cur_value_out == $past(cur_data_in))
      else $error("override not taken in monitor");
   setpt_keep_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !setpt_wr_in |=> $stable(setpt_out))
      else $error("set point moved without a write");
   prog_win_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      out_prog_drv_in != 6'h00 |=> (sys_output_out & $past(out_prog_drv_in))
         == ($past(gate_out) & $past(out_prog_drv_in)))
      else $error("force beat the program");
endmodule : blg_logic_top

// ==== dv/blg_logic_top_bench.sv ====
`timescale 1ns/10ps
module blg_logic_top_bench;
   import blg_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] key_pin_in;
   logic [3:0] hw_input_pin_in, input_force_req_in;
   logic [3:0] and_val_in, and_con_in, or_val_in, or_con_in;
   logic [3:0] nand_val_in, nand_con_in, nor_val_in, nor_con_in;
   logic not_val_in, not_con_in, monitor_mode_in;
   logic [1:0] xor_val_in, xor_con_in;
   logic [23:0] mbit_set_in, mbit_val_in, mbit_out, mexp;
   logic [5:0] out_prog_drv_in, force_req_in, force_val_in, gexp;
   logic cur_wr_in, setpt_wr_in, blk_add_in, blk_del_in;
   logic [15:0] cur_data_in, setpt_data_in, cur_value_out, setpt_out;
   logic [5:0] gate_out, sys_output_out;
   logic [7:0] key_out;
   logic [3:0] hw_input_out;
   logic scan_done_out, edit_ok_out, edit_reject_out;
   int err_count = 0;
   int checks_done = 0;
   int seed = 32'h2F1A;
   always #2.5 clk_sys_in = ~clk_sys_in;
   blg_logic_top #(.SCAN_CYCLES(8)) dut_u (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .key_pin_in(key_pin_in), .hw_input_pin_in(hw_input_pin_in),
      .and_val_in(and_val_in), .and_con_in(and_con_in),
      .or_val_in(or_val_in), .or_con_in(or_con_in),
      .not_val_in(not_val_in), .not_con_in(not_con_in),
      .xor_val_in(xor_val_in), .xor_con_in(xor_con_in),
      .nand_val_in(nand_val_in), .nand_con_in(nand_con_in),
      .nor_val_in(nor_val_in), .nor_con_in(nor_con_in),
      .monitor_mode_in(monitor_mode_in), .mbit_set_in(mbit_set_in),
      .mbit_val_in(mbit_val_in), .out_prog_drv_in(out_prog_drv_in),
      .force_req_in(force_req_in), .force_val_in(force_val_in),
      .input_force_req_in(input_force_req_in), .cur_wr_in(cur_wr_in),
      .cur_data_in(cur_data_in), .setpt_wr_in(setpt_wr_in),
      .setpt_data_in(setpt_data_in), .blk_add_in(blk_add_in),
      .blk_del_in(blk_del_in), .gate_out(gate_out),
      .sys_output_out(sys_output_out), .key_out(key_out),
      .hw_input_out(hw_input_out), .mbit_out(mbit_out),
      .scan_done_out(scan_done_out), .cur_value_out(cur_value_out),
      .setpt_out(setpt_out), .edit_ok_out(edit_ok_out),
      .edit_reject_out(edit_reject_out));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic end_of_test;
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // unconnected pins folded in by mask; empty and/nand/nor/not read low
   function automatic logic [5:0] gate_f();
      logic [5:0] g;
      g[0] = (and_con_in != 4'h0) && (&(and_val_in | ~and_con_in));
      g[1] = |(or_val_in & or_con_in);
      g[2] = not_con_in & ~not_val_in;
      g[3] = ^(xor_val_in & xor_con_in);
      g[4] = (nand_con_in != 4'h0) && !(&(nand_val_in | ~nand_con_in));
      g[5] = (nor_con_in != 4'h0) && !(|(nor_val_in & nor_con_in));
      return g;
   endfunction : gate_f
   // bounded wait; the flag is read at the falling edge once settled
   task automatic wait_scan;
      int n;
      n = 0;
      @(negedge clk_sys_in);
      while (scan_done_out !== 1'b1) begin
         n++;
         if (n > 40) begin
            chk("scan_timeout", 32'h1, 32'h0);
            end_of_test();
         end
         @(negedge clk_sys_in);
      end
   endtask : wait_scan
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : cyc
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {key_pin_in, hw_input_pin_in, input_force_req_in} = '0;
      {and_val_in, and_con_in, or_val_in, or_con_in} = '0;
      {nand_val_in, nand_con_in, nor_val_in, nor_con_in} = '0;
      {not_val_in, not_con_in, xor_val_in, xor_con_in} = '0;
      {monitor_mode_in, mbit_set_in, mbit_val_in} = '0;
      {out_prog_drv_in, force_req_in, force_val_in} = '0;
      {cur_wr_in, cur_data_in, setpt_wr_in, setpt_data_in} = '0;
      {blk_add_in, blk_del_in} = '0;
      mexp = '0;
      cyc(4);
      sys_rst_in = 1'b0;
      chk("gate_rst", 32'h0, 32'(gate_out));
      chk("mbit_rst", 32'h0, 32'(mbit_out));
      // gate truth: corners first, then random wiring
      for (int i = 0; i < 40; i++) begin
         {and_val_in, or_val_in, nand_val_in, nor_val_in} = 16'($random(seed));
         {and_con_in, or_con_in, nand_con_in, nor_con_in} = 16'($random(seed));
         {not_val_in, not_con_in, xor_val_in, xor_con_in} = 6'($random(seed));
         if (i == 0) begin
            {and_con_in, or_con_in, nand_con_in, nor_con_in} = '0;
            {not_con_in, xor_con_in} = '0;
         end else if (i < 3) begin
            {and_con_in, or_con_in, nand_con_in, nor_con_in} = '1;
            {not_con_in, xor_con_in} = '1;
            {and_val_in, or_val_in, nand_val_in, nor_val_in} = {16{i[0]}};
            {not_val_in, xor_val_in} = {3{i[0]}};
         end
         gexp = gate_f();
         wait_scan();
         wait_scan();
         chk("gate_out", 32'(gexp), 32'(gate_out));
         chk("gate_nx", 32'(gexp[5:2]), 32'(gate_out[5:2]));
         chk("gate_nn", 32'(gexp[5:4]), 32'(gate_out[5:4]));
      end
      // keys and hardware inputs follow pins; forcing inputs is ignored
      for (int i = 0; i < 6; i++) begin
         key_pin_in = 8'($random(seed));
         {hw_input_pin_in, input_force_req_in} = 8'($random(seed));
         cyc(4);
         chk("key_out", 32'(key_pin_in), 32'(key_out));
         chk("hw_in", 32'(hw_input_pin_in), 32'(hw_input_out));
         mbit_set_in = 24'($random(seed));
         mbit_val_in = 24'($random(seed));
         mexp = (mexp & ~mbit_set_in) | (mbit_val_in & mbit_set_in);
         cyc(1);
         mbit_set_in = '0;
         cyc(1);
         chk("mbit_out", 32'(mexp), 32'(mbit_out));
      end
      // monitor: force, volatile value, set point, refused edit
      monitor_mode_in = 1'b1;
      out_prog_drv_in = 6'($random(seed));
      force_val_in = 6'($random(seed));
      force_req_in = 6'h3F;
      cur_wr_in = 1'b1;
      cur_data_in = 16'($random(seed));
      setpt_wr_in = 1'b1;
      setpt_data_in = 16'($random(seed));
      blk_add_in = 1'b1;
      cyc(1);
      {force_req_in, cur_wr_in, setpt_wr_in, blk_add_in} = '0;
      chk("cur_val", 32'(cur_data_in), 32'(cur_value_out));
      chk("setpt", 32'(setpt_data_in), 32'(setpt_out));
      chk("reject", 32'h1, 32'(edit_reject_out));
      chk("ok_mon", 32'h0, 32'(edit_ok_out));
      cyc(2);
      chk("forced", 32'((out_prog_drv_in & gexp) |
         (~out_prog_drv_in & force_val_in)), 32'(sys_output_out));
      // leaving monitor drops the overrides, keeps the set point
      monitor_mode_in = 1'b0;
      blk_del_in = 1'b1;
      cyc(1);
      blk_del_in = 1'b0;
      chk("edit_ok", 32'h1, 32'(edit_ok_out));
      chk("rej_run", 32'h0, 32'(edit_reject_out));
      cyc(2);
      chk("cur_drop", 32'h0, 32'(cur_value_out));
      chk("setpt_kept", 32'(setpt_data_in), 32'(setpt_out));
      chk("unforced", 32'(gexp), 32'(sys_output_out));
      end_of_test();
   end
endmodule : blg_logic_top_bench
